// ===== sccp_host.sv
// Purpose: Host controller model for the serial command port
// Assumes: Open-drain lines resolved with pull-ups in the bench
// Notes: Bit time is counted in falling edges of the system clock
`timescale 1ns/10ps
module sccp_host (
  // Clock
  input wire logic clk,
  // Resolved bus levels
  input wire logic scl,
  input wire logic sda,
  // High while the host pulls a line low
  output logic scl_low,
  output logic sda_low,
  // Clock held low past the wait limit
  output logic hang
);
  // Bench bound on a stretch; far below the worst case, keeps runs short
  localparam int STRETCH_LIMIT = 20000;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    hang = 1'b0;
  end
  // Idle for n falling edges
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One bit clock; the device may stretch the low phase
  task automatic pulse(output logic smp);
    int k;
    k = 0;
    gap(4);
    scl_low <= 1'b0;
    @(negedge clk);
    while (scl !== 1'b1 && k < STRETCH_LIMIT) begin
      @(negedge clk);
      k++;
    end
    if (k >= STRETCH_LIMIT)
      hang <= 1'b1;
    gap(3);
    smp = sda;
    gap(3);
    scl_low <= 1'b1;
    gap(2);
  endtask
  // Start or repeated start: data falls while clock is high
  task automatic start();
    int k;
    k = 0;
    sda_low <= 1'b0;
    gap(2);
    scl_low <= 1'b0;
    @(negedge clk);
    while (scl !== 1'b1 && k < STRETCH_LIMIT) begin
      @(negedge clk);
      k++;
    end
    gap(4);
    sda_low <= 1'b1;
    gap(4);
    scl_low <= 1'b1;
    gap(2);
  endtask
  // Stop: data rises while clock is high
  task automatic stop();
    sda_low <= 1'b1;
    gap(4);
    scl_low <= 1'b0;
    gap(6);
    sda_low <= 1'b0;
    gap(8);
  endtask
  // Send one byte msb first, return the acknowledge
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_low <= ~b[i];
      pulse(s);
    end
    sda_low <= 1'b0;
    pulse(s);
    ack = (s === 1'b0);
  endtask
  // Receive one byte; the last one is not acknowledged
  task automatic get(input logic last, output logic [7:0] b);
    logic s;
    sda_low <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pulse(s);
      b[i] = s;
    end
    sda_low <= ~last;
    pulse(s);
  endtask
endmodule

// ===== sccp_pkg.sv
// Purpose: Constants and types for the serial control command port
// Assumes: 100 MHz system clock; serial pins are asynchronous
// Notes: One package shared by the single design file
//
// What this block does
// - Answer address 3a write, 3b read
// - Accesses are 16-bit words, high byte first
// - Device stretches clock low for one system clock after each written data word
// - Sub-addresses 68 command, 69 response, 6a control
// - Reads need repeated start with read address
// - Wait points may delay up to 4 ms
// - Commands run without stalling data streams
// - Control word is write only
// - Control bit 8 set causes soft reset
// - Data port 16 bits, msb first
// - First nibble after sub-address is command code
// - Decode codes 0,1,5,6,9,d; codes 8,a,b,e,f are named but ignored
// - Nibbles numbered from zero at lsb end
// - Internal words 20 bits, two bus words
// - 256 data registers, 8-bit register number
// - Values are 20-bit two's complement fractions
// - Run address top nibble equals command code
// - Run address zero freezes firmware
// - After reset enter default entry automatically
// - Select component number in lowest three bits
// - Host syncs on channel and audio frame flags
// - Ancillary data new once per audio frame
// - Ancillary parameter: 6-bit offset, 6-bit count
package sccp_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h1D;
  localparam logic [7:0] SUB_CMD = 8'h68;
  localparam logic [7:0] SUB_RSP = 8'h69;
  localparam logic [7:0] SUB_CTL = 8'h6A;
  localparam int CTL_RESET_BIT = 8;
  localparam logic [15:0] DEFAULT_ENTRY = 16'h0100;
  localparam logic [7:0] FLAG_REG = 8'hC8;
  localparam int CLK_MHZ = 100;
  localparam int WAIT_MAX_US = 4000;
  localparam int WAIT_MAX_CYC = WAIT_MAX_US * CLK_MHZ;
  // Command codes
  localparam logic [3:0] CMD_RUN = 4'h0;
  localparam logic [3:0] CMD_RUNCFG = 4'h1;
  localparam logic [3:0] CMD_SELSC = 4'h5;
  localparam logic [3:0] CMD_ANC = 4'h6;
  localparam logic [3:0] CMD_HDR = 4'h8;
  localparam logic [3:0] CMD_WREG = 4'h9;
  localparam logic [3:0] CMD_WMEM0 = 4'hA;
  localparam logic [3:0] CMD_WMEM1 = 4'hB;
  localparam logic [3:0] CMD_RREG = 4'hD;
  localparam logic [3:0] CMD_RMEM0 = 4'hE;
  localparam logic [3:0] CMD_RMEM1 = 4'hF;
  // Serial engine states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_SUB, ST_WDATA, ST_RDATA, ST_ACK, ST_RACK, ST_SKIP
  } sccp_state_t;
  // Firmware-side view of a decoded command word
  typedef struct packed {
    logic [3:0] code;
    logic [11:0] param;
  } sccp_cmd_t;
  // Firmware status seen by the block
  typedef struct packed {
    logic frozen;
    logic cfg_remap;
    logic [15:0] pc;
  } sccp_run_t;
endpackage

// ===== sccp_top.sv
// Purpose: Two-wire slave command port with command interpreter
// Assumes: Serial clock and data pass two-flop synchronisers
// Notes: Firmware side is a simple register model; memory commands are ignored
`timescale 1ns/10ps
module sccp_top (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Serial pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Frame indications
  input wire logic channel_frame_i,
  input wire logic audio_frame_i,
  output logic channel_frame_flag,
  output logic audio_frame_flag,
  // Control outputs
  output logic [3:0] task_select_bits,
  output logic soft_reset_pulse,
  output logic [2:0] service_component,
  output logic [15:0] run_pc,
  output logic frozen,
  output logic cfg_remap
);
  // Synchronisers: first stage read only by second
  logic [1:0] scl_s_q, sda_s_q;
  logic scl_d1_q, sda_d1_q;
  always_ff @(posedge clk) begin
    scl_s_q <= {scl_s_q[0], scl_i};
    sda_s_q <= {sda_s_q[0], sda_i};
    scl_d1_q <= scl_s_q[1];
    sda_d1_q <= sda_s_q[1];
  end
  wire scl = scl_s_q[1];
  wire sda = sda_s_q[1];
  wire scl_rise = scl & ~scl_d1_q;
  wire scl_fall = ~scl & scl_d1_q;
  wire start_c = scl & scl_d1_q & sda_d1_q & ~sda;
  wire stop_c = scl & scl_d1_q & ~sda_d1_q & sda;

  // Frame flags passed through synchronisers
  logic [1:0] cf_s_q, af_s_q;
  always_ff @(posedge clk) begin
    cf_s_q <= {cf_s_q[0], channel_frame_i};
    af_s_q <= {af_s_q[0], audio_frame_i};
  end

  sccp_pkg::sccp_state_t st_q;
  logic [7:0] sh_q;
  logic [3:0] bit_q;
  logic rw_q;
  logic [7:0] sub_q;
  logic hi_q;
  logic [7:0] hib_q;
  logic [15:0] tx_q;
  logic sda_oe_q;
  logic hold_q;
  // Set when the byte just acked was the address byte
  logic acked_q;
  // Command assembly
  logic [2:0] widx_q;
  logic [15:0] w0_q;
  logic [7:0] ridx_q;
  // Firmware state: two's complement 20-bit cells
  logic [19:0] regs_q [256];
  // Value waiting for the read port
  logic [19:0] rd_q;
  logic [3:0] task_q;
  logic [2:0] sc_q;
  logic [15:0] pc_q;
  logic frz_q, remap_q, srst_pend_q;

  wire [6:0] addr7 = sh_q[7:1];
  wire addr_hit = addr7 == sccp_pkg::DEV_ADDR;
  wire [7:0] byte_in = {sh_q[6:0], sda};
  // Full byte is already in sh_q at the byte-end fall
  wire [15:0] word_in = {hib_q, sh_q};
  wire [3:0] code = w0_q[15:12];
  wire [3:0] code_new = word_in[15:12];
  // Run and run-config share the only-word form
  wire is_run = code_new == sccp_pkg::CMD_RUN
    || code_new == sccp_pkg::CMD_RUNCFG;
  wire is_rreg = code_new == sccp_pkg::CMD_RREG;
  wire is_anc = code_new == sccp_pkg::CMD_ANC;
  wire is_sel = code == sccp_pkg::CMD_SELSC;
  wire is_wreg = code == sccp_pkg::CMD_WREG;
  // Register reads: first word carries d4, second d3..d0
  wire [19:0] rsp_word = ridx_q[0] ? {4'h0, rd_q[15:0]}
    : {16'h0000, rd_q[19:16]};

  // Serial engine: bit shifter, ack, clock stretch
  always_ff @(posedge clk) begin
    soft_reset_pulse <= 1'b0;
    if (srst) begin
      st_q <= sccp_pkg::ST_IDLE;
      sda_oe_q <= 1'b0;
      hold_q <= 1'b0;
      bit_q <= 4'h0;
      hi_q <= 1'b0;
      widx_q <= 3'h0;
      ridx_q <= 8'h00;
      task_q <= 4'h0;
      sc_q <= 3'h0;
      pc_q <= sccp_pkg::DEFAULT_ENTRY;
      frz_q <= 1'b0;
      remap_q <= 1'b0;
      rd_q <= 20'h00000;
      srst_pend_q <= 1'b0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      sub_q <= 8'h00;
      acked_q <= 1'b0;
    end else if (start_c) begin
      st_q <= sccp_pkg::ST_ADDR;
      bit_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (stop_c) begin
      st_q <= sccp_pkg::ST_IDLE;
      sda_oe_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      // Stretch at the end of each data word's low byte while command executes
      hold_q <= 1'b0;
      case (st_q)
        sccp_pkg::ST_ADDR, sccp_pkg::ST_SUB, sccp_pkg::ST_WDATA: begin
          if (scl_rise) begin
            sh_q <= byte_in;
            bit_q <= bit_q + 4'h1;
          end
          if (scl_fall && bit_q == 4'h8) begin
            bit_q <= 4'h0;
            acked_q <= st_q == sccp_pkg::ST_ADDR;
            if (st_q == sccp_pkg::ST_ADDR && !addr_hit) begin
              // Foreign address: stay off the bus until a start
              st_q <= sccp_pkg::ST_SKIP;
            end else begin
              sda_oe_q <= 1'b1;
              st_q <= sccp_pkg::ST_ACK;
              if (st_q == sccp_pkg::ST_ADDR) begin
                rw_q <= sh_q[0];
                hi_q <= 1'b0;
                ridx_q <= 8'h00;
              end else if (st_q == sccp_pkg::ST_SUB) begin
                sub_q <= sh_q;
                hi_q <= 1'b0;
                widx_q <= 3'h0;
              end else begin
                hi_q <= ~hi_q;
                if (!hi_q) begin
                  hib_q <= sh_q;
                end else begin
                  hold_q <= 1'b1;
                  if (sub_q == sccp_pkg::SUB_CTL) begin
                    task_q <= sh_q[3:0];
                    if (hib_q[sccp_pkg::CTL_RESET_BIT - 8]) begin
                      srst_pend_q <= 1'b1;
                      soft_reset_pulse <= 1'b1;
                    end
                  end else if (sub_q == sccp_pkg::SUB_CMD) begin
                    widx_q <= widx_q + 3'h1;
                    if (widx_q == 3'h0) begin
                      w0_q <= word_in;
                      // Single-word commands act at once
                      if (is_run) begin
                        pc_q <= word_in;
                        frz_q <= word_in == 16'h0000;
                        remap_q <= code_new == sccp_pkg::CMD_RUNCFG;
                      end
                      if (is_rreg) begin
                        rd_q <= regs_q[word_in[11:4]];
                      end
                      // No buffer here: the port echoes the request
                      if (is_anc) begin
                        rd_q <= {8'h00, word_in[11:0]};
                      end
                    end else if (widx_q == 3'h1) begin
                      if (is_sel) begin
                        sc_q <= word_in[2:0];
                      end
                      if (is_wreg) begin
                        regs_q[w0_q[11:4]] <= {w0_q[3:0], word_in};
                      end
                    end
                  end
                end
              end
            end
          end
        end
        sccp_pkg::ST_ACK: begin
          // Ack stands until the host's next falling edge
          if (scl_fall) begin
            sda_oe_q <= 1'b0;
            if (rw_q && acked_q) begin
              st_q <= sccp_pkg::ST_RDATA;
              tx_q <= {rsp_word[15:8], 8'h00};
              sda_oe_q <= ~rsp_word[15];
            end else if (acked_q) begin
              st_q <= sccp_pkg::ST_SUB;
            end else begin
              st_q <= sccp_pkg::ST_WDATA;
            end
          end
        end
        sccp_pkg::ST_RDATA: begin
          // Read bytes go out msb first; oe low lets pull-up show a one
          if (scl_fall) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              sda_oe_q <= 1'b0;
              st_q <= sccp_pkg::ST_RACK;
              bit_q <= 4'h0;
            end else begin
              tx_q <= {tx_q[14:0], 1'b0};
              sda_oe_q <= ~tx_q[14];
            end
          end
        end
        sccp_pkg::ST_RACK: begin
          if (scl_rise) begin
            if (sda) begin
              st_q <= sccp_pkg::ST_SKIP;
            end else begin
              hi_q <= ~hi_q;
              if (hi_q) begin
                ridx_q <= ridx_q + 8'h01;
              end
            end
          end
          if (scl_fall && st_q == sccp_pkg::ST_RACK) begin
            st_q <= sccp_pkg::ST_RDATA;
            tx_q <= hi_q ? {rsp_word[7:0], 8'h00}
              : {rsp_word[15:8], 8'h00};
            sda_oe_q <= hi_q ? ~rsp_word[7] : ~rsp_word[15];
          end
        end
        default: ;
      endcase
      // Soft reset lands after the ack so the host still sees it
      if (srst_pend_q) begin
        srst_pend_q <= 1'b0;
        sc_q <= 3'h0;
        pc_q <= sccp_pkg::DEFAULT_ENTRY;
        frz_q <= 1'b0;
        remap_q <= 1'b0;
      end
    end
  end

  assign sda_oe = sda_oe_q;
  // Open drain: only the enable ever changes
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign scl_oe = hold_q;
  assign task_select_bits = task_q;
  assign service_component = sc_q;
  assign run_pc = pc_q;
  assign frozen = frz_q;
  assign cfg_remap = remap_q;
  assign channel_frame_flag = cf_s_q[1];
  assign audio_frame_flag = af_s_q[1];

  // Checks on the serial engine and command interpreter, all in the system clock
  default clocking cb_sys @(posedge clk);
  endclocking
  default disable iff (srst);
  // Last falling edge of a received byte
  sequence s_byte_end;
    scl_fall && bit_q == 4'h8;
  endsequence
  // Second byte of the first command word completes
  sequence s_cmd_word;
    (st_q == sccp_pkg::ST_WDATA && hi_q && sub_q == sccp_pkg::SUB_CMD
      && widx_q == 3'h0) ##0 s_byte_end;
  endsequence
  a_addr_ack: assert property (
    (st_q == sccp_pkg::ST_ADDR && addr_hit) ##0 s_byte_end |=> sda_oe_q
  ) else $error("matching address not acknowledged");
  a_foreign_skip: assert property (
    (st_q == sccp_pkg::ST_ADDR && !addr_hit) ##0 s_byte_end
      |=> (!sda_oe_q && st_q == sccp_pkg::ST_SKIP)
  ) else $error("foreign address not ignored");
  a_stretch_brief: assert property (
    scl_oe |=> !scl_oe
  ) else $error("clock stretch held too long");
  a_read_start: assert property (
    (st_q == sccp_pkg::ST_ACK && scl_fall && rw_q && acked_q)
      |=> st_q == sccp_pkg::ST_RDATA
  ) else $error("read address did not start data out");
  a_run_entry: assert property (
    s_cmd_word ##0 is_run |=> pc_q == $past(word_in)
  ) else $error("run address not taken");
  a_freeze_run: assert property (
    s_cmd_word ##0 (word_in == 16'h0000) |=> frz_q
  ) else $error("run at zero did not freeze");
  a_soft_reset: assert property (
    soft_reset_pulse
      |-> ##[1:4] (pc_q == sccp_pkg::DEFAULT_ENTRY && !frz_q)
  ) else $error("soft reset did not restore entry");
endmodule

// ===== serial_control_command_port_bench.sv
// Purpose: Self-checking bench for the serial command port
// Assumes: Host model drives the two-wire bus at 130 ns per bit
// Notes: Expected values worked out from the command encoding
`timescale 1ns/10ps
module serial_control_command_port_bench;
  logic clk, srst, scl, sda, h_scl, h_sda, hang, rst_seen;
  logic scl_o, scl_oe, sda_o, sda_oe, ch_i, au_i, ch_f, au_f;
  logic [3:0] tsel;
  logic soft_rst, frozen, remap;
  logic [2:0] comp;
  logic [15:0] pc;
  int failures = 0;
  int cmp_count = 0;
  // Wired-and bus with pull-ups
  assign scl = ~(h_scl | scl_oe);
  assign sda = ~(h_sda | sda_oe);
  sccp_top u_dut (.clk(clk), .srst(srst), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .channel_frame_i(ch_i), .audio_frame_i(au_i),
    .channel_frame_flag(ch_f), .audio_frame_flag(au_f),
    .task_select_bits(tsel), .soft_reset_pulse(soft_rst),
    .service_component(comp), .run_pc(pc), .frozen(frozen),
    .cfg_remap(remap));
  sccp_host u_host (.clk(clk), .scl(scl), .sda(sda), .scl_low(h_scl),
    .sda_low(h_sda), .hang(hang));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Sticky capture of the one-cycle reset pulse
  always @(posedge clk)
    if (soft_rst === 1'b1) rst_seen <= 1'b1;
  // A stuck clock ends the run at once
  always @(posedge hang) begin
    failures++;
    final_report();
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Write n words to a sub-address in one telegram
  task automatic wr(input logic [7:0] sub, input logic [31:0] w, int n);
    logic a;
    u_host.start();
    u_host.put(8'h3A, a);
    check(a, 1'b1);
    u_host.put(sub, a);
    check(a, 1'b1);
    for (int i = n - 1; i >= 0; i--) begin
      u_host.put(w[16*i+8 +: 8], a);
      check(a, 1'b1);
      u_host.put(w[16*i +: 8], a);
      check(a, 1'b1);
    end
    u_host.stop();
  endtask
  task automatic t_control();
    wr(8'h6A, 32'h0003, 1);
    check(tsel, 4'h3);
    rst_seen = 1'b0;
    wr(8'h6A, 32'h0100, 1);
    check(tsel, 4'h0);
    check(rst_seen, 1'b1);
    check(pc, 16'h0100);
  endtask
  task automatic t_run();
    wr(8'h68, 32'h0345, 1);
    check(pc, 16'h0345);
    check(frozen, 1'b0);
    wr(8'h68, 32'h1100, 1);
    check(remap, 1'b1);
    wr(8'h68, 32'h0000, 1);
    check(frozen, 1'b1);
    wr(8'h6A, 32'h0100, 1);
    check({frozen, remap}, 2'b00);
    check(pc, 16'h0100);
  endtask
  task automatic t_select();
    wr(8'h68, 32'h5000_0007, 2);
    check(comp, 3'h7);
    wr(8'h68, 32'h5000_0002, 2);
    check(comp, 3'h2);
  endtask
  // Foreign address is ignored, then a read with a closing nak
  task automatic t_read();
    logic a;
    logic [7:0] b0, b1, b2, b3;
    u_host.start();
    u_host.put(8'h3C, a);
    check(a, 1'b0);
    u_host.stop();
    wr(8'h68, 32'h9AA8_1234, 2);
    wr(8'h68, 32'hDAA0, 1);
    u_host.start();
    u_host.put(8'h3A, a);
    u_host.put(8'h69, a);
    u_host.start();
    u_host.put(8'h3B, a);
    check(a, 1'b1);
    u_host.get(1'b0, b0);
    u_host.get(1'b0, b1);
    u_host.get(1'b0, b2);
    u_host.get(1'b1, b3);
    u_host.stop();
    check({b0, b1}, 16'h0008);
    check({b2, b3}, 16'h1234);
    check(sda_oe, 1'b0);
  endtask
  task automatic t_frames();
    @(negedge clk);
    ch_i = 1'b1;
    au_i = 1'b1;
    repeat (4) @(negedge clk);
    check({ch_f, au_f}, 2'b11);
    ch_i = 1'b0;
    repeat (4) @(negedge clk);
    check({ch_f, au_f}, 2'b01);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    srst = 1'b1;
    ch_i = 1'b0;
    au_i = 1'b0;
    rst_seen = 1'b0;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    check({scl_oe, sda_oe, frozen, remap}, 4'h0);
    check(pc, 16'h0100);
    t_control();
    t_run();
    t_select();
    t_read();
    wr(8'h68, 32'h0345, 1);
    check(pc, 16'h0345);
    t_frames();
    final_report();
  end
endmodule
